// [src/css_pkg.sv]
// Package for the command source selector: offsets, codes, structs
package css_pkg;
  localparam logic [7:0] CSS_LINK_SRC_OFS = 8'h00;
  localparam logic [7:0] CSS_FB_PRIO_OFS = 8'h04;
  localparam logic [7:0] CSS_OVR_OFS = 8'h08;
  localparam logic [7:0] CSS_STATUS_OFS = 8'h0c;
  localparam logic [7:0] CSS_ASSIGN_OFS = 8'h10;
  localparam logic [7:0] CSS_CMD_OFS = 8'h30;
  localparam logic [7:0] CSS_SET_OFS = 8'h50;
  localparam int CSS_NTERM = 7;
  localparam int CSS_NSET = 20;
  localparam logic [3:0] CSS_LINK_SRC_MAX = 4'h8;
  localparam logic [10:0] CSS_GATE_POS = 11'h018;
  localparam logic [10:0] CSS_GATE_NEG = 11'h400;
  localparam logic [3:0] CSS_LINK_SRC_RST = 4'h0;
  localparam logic [1:0] CSS_FB_PRIO_RST = 2'h0;
  localparam logic [1:0] CSS_OVR_RST = 2'h0;
  localparam logic [10:0] CSS_ASSIGN_RST = 11'h000;
  localparam logic [15:0] CSS_CMD_RST = 16'h0000;
  localparam logic [7:0] CSS_SET_RST = 8'h00;
  localparam int CSS_RUN_FWD_BIT = 0;
  localparam int CSS_RUN_X1_BIT = 2;
  localparam int CSS_TERM_FWD = 5;
  localparam int CSS_TERM_X1 = 0;
  typedef enum logic [1:0] {CSS_SRC_LOCAL, CSS_SRC_PORT1, CSS_SRC_PORT2, CSS_SRC_FBUS} css_src_t;
  typedef struct packed {
    logic [15:0] freq;
    logic forward_run_terminal;
    logic x1;
  } css_cmd_t;
  typedef struct packed {
    logic active;
    logic [15:0] freq;
    logic forward_run_terminal;
    logic x1;
  } css_fbus_t;
endpackage

// [src/css_selector.sv]
// Command source selector with APB register access
`timescale 1ns/1ps
// Overview of operation
// - Link source 0 keeps local; 1 to 8 route frequency, run or both to ports.
// - Link invalid: frequency from analog, forward and X1 from terminals.
// - Settings readable and writable regardless of link source value.
// - Gate code 24 may sit on any multi-input or forward/backward terminal.
// - No terminal carrying the gate means link always valid.
// - Positive logic: gate off invalid, gate on valid.
// - Command words cleared at power-on; host rewrites them.
// - Words written while invalid are stored, applied once link valid.
// - Gate code 1024 inverts the gate's on/off meaning.
// - Field-bus priority setting lets field-bus commands override RS-485.
// - Override 1 to 3 forces frequency, run, or both to link.
// - Nonzero override forces link valid without touching link source.
// - Override is volatile and returns to 0 at reset.
// - Smallest variant: keypad nonzero override behaves as 0.
// - Two independent sets of ten serial settings, one per port.
// - Link-written digital inputs switch together with run source.
module css_selector
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminals (asynchronous pins): multi-inputs 0..4, forward 5, backward 6
  input wire logic [6:0] term_pins,
  // Analog frequency word, same clock domain
  input wire logic [15:0] analog_freq,
  // Keypad override entry
  input wire logic kp_ovr_wr,
  input wire logic [1:0] kp_ovr_data,
  input wire logic small_variant,
  // Field-bus option
  input wire css_pkg::css_fbus_t fbus_in,
  // Selected commands
  output css_pkg::css_cmd_t cmd_out,
  output css_pkg::css_src_t freq_src,
  output css_pkg::css_src_t run_src,
  output logic link_valid
);
  import css_pkg::*;

  logic [3:0] link_source_select_r;
  logic [1:0] fieldbus_priority_select_r;
  logic [1:0] support_override_select_r;
  logic [10:0] assign_r [CSS_NTERM];
  logic [15:0] cmd_r [2][3];
  logic [7:0] set_r [CSS_NSET];
  logic [6:0] s1_r;
  logic [6:0] s2_r;
  logic [6:0] s3_r;
  logic [6:0] term_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  css_cmd_t cmd_r_out;
  css_src_t freq_src_r;
  css_src_t run_src_r;
  logic link_valid_r;

  // Port index of link source setting for frequency / run (0 none, 1, 2)
  function automatic logic [1:0] freq_port(input logic [3:0] v);
    case (v)
      4'h1, 4'h3, 4'h7: freq_port = 2'h1;
      4'h4, 4'h5, 4'h8: freq_port = 2'h2;
      default: freq_port = 2'h0;
    endcase
  endfunction

  function automatic logic [1:0] run_port(input logic [3:0] v);
    case (v)
      4'h2, 4'h3, 4'h5: run_port = 2'h1;
      4'h6, 4'h7, 4'h8: run_port = 2'h2;
      default: run_port = 2'h0;
    endcase
  endfunction

  function automatic logic is_gate(input logic [10:0] c);
    is_gate = (c == CSS_GATE_POS) || (c == CSS_GATE_NEG);
  endfunction

  // Gate: first terminal holding the gate code wins
  logic gate_found;
  logic gate_on;
  logic gate_neg;
  always_comb
  begin
    gate_found = 1'b0;
    gate_on = 1'b0;
    gate_neg = 1'b0;
    for (int i = CSS_NTERM - 1; i >= 0; i--)
    begin
      if (is_gate(assign_r[i]))
      begin
        gate_found = 1'b1;
        gate_on = term_r[i];
        gate_neg = (assign_r[i] == CSS_GATE_NEG);
      end
    end
  end

  wire link_ok = !gate_found || (gate_on ^ gate_neg);

  // Decode of the source settings
  wire [1:0] fp = freq_port(link_source_select_r);
  wire [1:0] rp = run_port(link_source_select_r);
  wire ovr_f = support_override_select_r[0];
  wire ovr_r = support_override_select_r[1];
  // Override forces link valid; with no port named it uses port one
  wire [1:0] fp_ovr = (fp == 2'h0) ? 2'h1 : fp;
  wire [1:0] rp_ovr = (rp == 2'h0) ? 2'h1 : rp;
  wire [1:0] fsel = ovr_f ? fp_ovr : (link_ok ? fp : 2'h0);
  wire [1:0] rsel = ovr_r ? rp_ovr : (link_ok ? rp : 2'h0);
  wire fb_f = fbus_in.active && fieldbus_priority_select_r[0] && !ovr_f;
  wire fb_r = fbus_in.active && fieldbus_priority_select_r[1] && !ovr_r;

  // Frequency word a has precedence over word b when nonzero
  wire [1:0] fi = (fsel == 2'h2) ? 2'h1 : 2'h0;
  wire [1:0] ri = (rsel == 2'h2) ? 2'h1 : 2'h0;
  wire [15:0] link_freq = (cmd_r[fi[0]][0] != CSS_CMD_RST) ? cmd_r[fi[0]][0] : cmd_r[fi[0]][1];
  wire [15:0] link_run = cmd_r[ri[0]][2];

  css_cmd_t cmd_nxt;
  css_src_t freq_src_nxt;
  css_src_t run_src_nxt;
  always_comb
  begin
    if (fb_f)
    begin
      cmd_nxt.freq = fbus_in.freq;
      freq_src_nxt = CSS_SRC_FBUS;
    end
    else if (fsel != 2'h0)
    begin
      cmd_nxt.freq = link_freq;
      freq_src_nxt = (fsel == 2'h1) ? CSS_SRC_PORT1 : CSS_SRC_PORT2;
    end
    else
    begin
      cmd_nxt.freq = analog_freq;
      freq_src_nxt = CSS_SRC_LOCAL;
    end
    if (fb_r)
    begin
      cmd_nxt.forward_run_terminal = fbus_in.forward_run_terminal;
      cmd_nxt.x1 = fbus_in.x1;
      run_src_nxt = CSS_SRC_FBUS;
    end
    else if (rsel != 2'h0)
    begin
      cmd_nxt.forward_run_terminal = link_run[CSS_RUN_FWD_BIT];
      cmd_nxt.x1 = link_run[CSS_RUN_X1_BIT];
      run_src_nxt = (rsel == 2'h1) ? CSS_SRC_PORT1 : CSS_SRC_PORT2;
    end
    else
    begin
      cmd_nxt.forward_run_terminal = term_r[CSS_TERM_FWD];
      cmd_nxt.x1 = term_r[CSS_TERM_X1];
      run_src_nxt = CSS_SRC_LOCAL;
    end
  end

  // Three-stage synchroniser; change accepted once stages two and three agree
  always_ff @(posedge mclk)
  begin
    s1_r <= term_pins;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      term_r <= 7'h00;
    else
      term_r <= (s2_r & ~(s2_r ^ s3_r)) | (term_r & (s2_r ^ s3_r));
  end

  // Outputs registered so a source change never glitches them
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cmd_r_out <= '0;
      freq_src_r <= CSS_SRC_LOCAL;
      run_src_r <= CSS_SRC_LOCAL;
      link_valid_r <= 1'b0;
    end
    else
    begin
      cmd_r_out <= cmd_nxt;
      freq_src_r <= freq_src_nxt;
      run_src_r <= run_src_nxt;
      link_valid_r <= link_ok;
    end
  end

  // APB decode; no wait state, read data registered during the setup phase
  wire acc = psel && penable && pready_r;
  wire [5:0] widx = paddr[7:2];
  wire [5:0] asg_base = CSS_ASSIGN_OFS[7:2];
  wire [5:0] set_base = CSS_SET_OFS[7:2];
  wire hit_asg = (paddr >= CSS_ASSIGN_OFS) && (paddr < CSS_CMD_OFS) && (widx - asg_base < 6'(CSS_NTERM));
  wire hit_cmd = (paddr >= CSS_CMD_OFS) && (paddr < CSS_SET_OFS) && (widx[1:0] != 2'h3);
  wire hit_set = (paddr >= CSS_SET_OFS) && (widx - set_base < 6'(CSS_NSET));
  wire [2:0] asg_i = 3'(widx - asg_base);
  // Port one words sit below 0x40, port two words from 0x40
  wire cmd_p = paddr[6];
  wire [1:0] cmd_k = paddr[3:2];
  wire [4:0] set_i = 5'(widx - set_base);
  wire hit_misc = (paddr == CSS_LINK_SRC_OFS) || (paddr == CSS_FB_PRIO_OFS)
                  || (paddr == CSS_OVR_OFS) || (paddr == CSS_STATUS_OFS);
  wire hit = (paddr[1:0] == 2'h0) && (hit_misc || hit_asg || hit_cmd || hit_set);
  // Refused addresses must not reach any setting, only raise the error
  wire wr = acc && pwrite && hit;

  logic [31:0] rd_nxt;
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (paddr == CSS_LINK_SRC_OFS)
      rd_nxt[3:0] = link_source_select_r;
    else if (paddr == CSS_FB_PRIO_OFS)
      rd_nxt[1:0] = fieldbus_priority_select_r;
    else if (paddr == CSS_OVR_OFS)
      rd_nxt[1:0] = support_override_select_r;
    else if (paddr == CSS_STATUS_OFS)
      rd_nxt[7:0] = {term_r[CSS_TERM_FWD], gate_found, link_valid_r, run_src_r, freq_src_r, 1'b0};
    else if (hit_asg)
      rd_nxt[10:0] = assign_r[asg_i];
    else if (hit_cmd)
      rd_nxt[15:0] = cmd_r[cmd_p][cmd_k];
    else if (hit_set)
      rd_nxt[7:0] = set_r[set_i];
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !(hit && paddr[1:0] == 2'h0);
      prdata_r <= (psel && !penable && hit) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Setting writes; accepted whatever the link source holds
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      link_source_select_r <= CSS_LINK_SRC_RST;
      fieldbus_priority_select_r <= CSS_FB_PRIO_RST;
      support_override_select_r <= CSS_OVR_RST;
      for (int i = 0; i < CSS_NTERM; i++)
        assign_r[i] <= CSS_ASSIGN_RST;
      for (int i = 0; i < CSS_NSET; i++)
        set_r[i] <= CSS_SET_RST;
    end
    else
    begin
      if (wr && paddr == CSS_LINK_SRC_OFS && pwdata[3:0] <= CSS_LINK_SRC_MAX)
        link_source_select_r <= pwdata[3:0];
      if (wr && paddr == CSS_FB_PRIO_OFS)
        fieldbus_priority_select_r <= pwdata[1:0];
      if (wr && paddr == CSS_OVR_OFS)
        support_override_select_r <= pwdata[1:0];
      else if (kp_ovr_wr)
        support_override_select_r <= small_variant ? CSS_OVR_RST : kp_ovr_data;
      if (wr && hit_asg)
        assign_r[asg_i] <= pwdata[10:0];
      if (wr && hit_set)
        set_r[set_i] <= pwdata[7:0];
    end
  end

  // Command words: cleared at power-on, stored even while link invalid
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int p = 0; p < 2; p++)
        for (int k = 0; k < 3; k++)
          cmd_r[p][k] <= CSS_CMD_RST;
    end
    else if (wr && hit_cmd)
      cmd_r[cmd_p][cmd_k] <= pwdata[15:0];
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cmd_out = cmd_r_out;
  assign freq_src = freq_src_r;
  assign run_src = run_src_r;
  assign link_valid = link_valid_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  local_only_a: assert property ((link_source_select_r == 4'h0 && ovr_f == 1'b0 && !fb_f)
    |=> freq_src == CSS_SRC_LOCAL) else $error("Frequency not local");
  link_off_a: assert property ((gate_found && !link_ok && !ovr_r && !fb_r)
    |=> (cmd_out.forward_run_terminal == $past(term_r[CSS_TERM_FWD]) && run_src == CSS_SRC_LOCAL))
    else $error("Run not from terminal");
  no_gate_a: assert property (!gate_found |-> link_ok) else $error("Link not valid without gate");
  gate_pos_a: assert property ((gate_found && !gate_neg) |-> (link_ok == gate_on))
    else $error("Gate polarity wrong");
  gate_neg_a: assert property ((gate_found && gate_neg) |-> (link_ok == !gate_on))
    else $error("Gate inversion wrong");
  cmd_store_a: assert property ((wr && hit_cmd) |=> cmd_r[$past(cmd_p)][$past(cmd_k)] == $past(pwdata[15:0]))
    else $error("Command word not stored");
  fbus_prio_a: assert property (fb_f |=> (freq_src == CSS_SRC_FBUS && cmd_out.freq == $past(fbus_in.freq)))
    else $error("Field-bus not taking frequency");
  ovr_force_a: assert property ((ovr_r && !link_ok) |=> run_src != CSS_SRC_LOCAL)
    else $error("Override did not force link");
  kp_small_a: assert property ((kp_ovr_wr && small_variant && !wr) |=> support_override_select_r == 2'h0)
    else $error("Keypad override not ignored");
  apb_ready_a: assert property ((psel && !penable) |=> pready ##1 !pready)
    else $error("Ready not one cycle");
  sync_hold_a: assert property ((s2_r != s3_r) |=> $stable(term_r)) else $error("Unsettled input taken");

  link_switch_c: cover property (!link_ok ##1 link_ok && rsel != 2'h0);
  port_two_c: cover property (freq_src == CSS_SRC_PORT2 && run_src == CSS_SRC_PORT2);
  fbus_take_c: cover property (run_src == CSS_SRC_FBUS);
  gate_neg_c: cover property (gate_found && gate_neg && link_ok);
endmodule

// [sim/css_host_model.sv]
// Host controller model: writes command words and settings over APB
`timescale 1ns/1ps
module css_host_model
(
  // Clock
  input wire logic mclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import css_pkg::*;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // One transfer; waits for pready with no limit of its own beyond the bench timeout
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// [sim/css_selector_tb_top.sv]
// Self-checking bench for the command source selector
`timescale 1ns/1ps
module css_selector_tb_top;
  import css_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] term_pins = 7'h00;
  logic [15:0] analog_freq = 16'h0777;
  logic kp_ovr_wr = 1'b0;
  logic [1:0] kp_ovr_data = 2'h0;
  logic small_variant = 1'b1;
  css_fbus_t fbus_in = '0;
  css_cmd_t cmd_out;
  css_src_t freq_src, run_src;
  logic link_valid;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [1:0] ft [9] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
  logic [1:0] rt [9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
  css_host_model host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  css_selector dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_pins(term_pins), .analog_freq(analog_freq), .kp_ovr_wr(kp_ovr_wr),
    .kp_ovr_data(kp_ovr_data), .small_variant(small_variant), .fbus_in(fbus_in),
    .cmd_out(cmd_out), .freq_src(freq_src), .run_src(run_src), .link_valid(link_valid));
  always #10 mclk = ~mclk;
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, eerr});
  endtask
  // Gate sync plus output register, with margin
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask
  task automatic src_chk(input logic [1:0] f, input logic [1:0] r);
    chk({30'h0, freq_src}, {30'h0, f});
    chk({30'h0, run_src}, {30'h0, r});
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd(CSS_LINK_SRC_OFS, 32'h0, 1'b0);
    rd(CSS_OVR_OFS, 32'h0, 1'b0);
    rd(CSS_CMD_OFS + 8'h08, 32'h0, 1'b0);
    rd(8'hfc, 32'h0, 1'b1);
    chk({31'h0, link_valid}, 32'h1);
    wr(CSS_CMD_OFS, 32'h1234);
    wr(CSS_CMD_OFS + 8'h08, 32'h0005);
    wr(CSS_CMD_OFS + 8'h10, 32'h0abc);
    wr(CSS_CMD_OFS + 8'h18, 32'h0004);
    for (int i = 0; i < 9; i++)
    begin
      wr(CSS_LINK_SRC_OFS, i);
      settle();
      src_chk(ft[i], rt[i]);
      chk({16'h0, cmd_out.freq}, ft[i] == 1 ? 32'h1234 : ft[i] == 2 ? 32'h0abc : 32'h0777);
      chk({30'h0, cmd_out.forward_run_terminal, cmd_out.x1}, rt[i] == 1 ? 32'h3 : rt[i] == 2 ? 32'h1 : 32'h0);
    end
    wr(CSS_LINK_SRC_OFS, 32'h9);
    rd(CSS_LINK_SRC_OFS, 32'h8, 1'b0);
    wr(CSS_LINK_SRC_OFS, 32'h3);
    wr(CSS_ASSIGN_OFS, {21'h0, CSS_GATE_POS});
    term_pins <= 7'h20;
    settle();
    chk({31'h0, link_valid}, 32'h0);
    chk({16'h0, cmd_out.freq}, 32'h0777);
    chk({30'h0, cmd_out.forward_run_terminal, cmd_out.x1}, 32'h2);
    wr(CSS_CMD_OFS, 32'h2222);
    settle();
    chk({16'h0, cmd_out.freq}, 32'h0777);
    term_pins <= 7'h01;
    settle();
    chk({31'h0, link_valid}, 32'h1);
    chk({16'h0, cmd_out.freq}, 32'h2222);
    wr(CSS_ASSIGN_OFS, {21'h0, CSS_GATE_NEG});
    settle();
    chk({31'h0, link_valid}, 32'h0);
    src_chk(2'h0, 2'h0);
    wr(CSS_OVR_OFS, 32'h1);
    settle();
    src_chk(2'h1, 2'h0);
    wr(CSS_OVR_OFS, 32'h3);
    settle();
    src_chk(2'h1, 2'h1);
    rd(CSS_LINK_SRC_OFS, 32'h3, 1'b0);
    wr(CSS_OVR_OFS, 32'h0);
    term_pins <= 7'h00;
    fbus_in <= '{active: 1'b1, freq: 16'h0555, forward_run_terminal: 1'b0, x1: 1'b0};
    wr(CSS_FB_PRIO_OFS, 32'h3);
    settle();
    src_chk(2'h3, 2'h3);
    chk({16'h0, cmd_out.freq}, 32'h0555);
    rd(CSS_STATUS_OFS, 32'h7e, 1'b0);
    @(posedge mclk);
    kp_ovr_wr <= 1'b1;
    kp_ovr_data <= 2'h3;
    @(posedge mclk);
    kp_ovr_wr <= 1'b0;
    rd(CSS_OVR_OFS, 32'h0, 1'b0);
    small_variant <= 1'b0;
    @(posedge mclk);
    kp_ovr_wr <= 1'b1;
    @(posedge mclk);
    kp_ovr_wr <= 1'b0;
    rd(CSS_OVR_OFS, 32'h3, 1'b0);
    wr(CSS_SET_OFS, 32'h11);
    wr(CSS_SET_OFS + 8'h28, 32'h22);
    rd(CSS_SET_OFS, 32'h11, 1'b0);
    rd(CSS_SET_OFS + 8'h28, 32'h22, 1'b0);
    // Second reset: override and command words must come back cleared
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd(CSS_OVR_OFS, 32'h0, 1'b0);
    rd(CSS_CMD_OFS, 32'h0, 1'b0);
    src_chk(2'h0, 2'h0);
    // Misaligned write is refused and must not plant a gate
    wr(CSS_ASSIGN_OFS + 8'h01, {21'h0, CSS_GATE_POS});
    rd(CSS_ASSIGN_OFS, 32'h0, 1'b0);
    // Gate on the backward terminal, nothing written since reset
    wr(CSS_LINK_SRC_OFS, 32'h3);
    wr(CSS_ASSIGN_OFS + 8'h18, {21'h0, CSS_GATE_POS});
    settle();
    chk({31'h0, link_valid}, 32'h0);
    term_pins <= 7'h40;
    settle();
    chk({31'h0, link_valid}, 32'h1);
    src_chk(2'h1, 2'h1);
    chk({14'h0, cmd_out}, 32'h0);
    close_out();
  end
endmodule
